// ==== design/bms_cfg.svh ====
// Purpose: constants for the burst message scheduler
// Assumes: 100 MHz reference clock, periods counted in processing ticks
// Notes:   period codes index the fixed period list
`ifndef BMS_CFG_SVH
`define BMS_CFG_SVH
`define BMS_SLOTS        3
`define BMS_VAL_W        32
// Period list in half-second units, code 0 = 0.5 s .. code 13 = 60 min
`define BMS_P_0_5S       24'h00_0001
`define BMS_P_1S         24'h00_0002
`define BMS_P_2S         24'h00_0004
`define BMS_P_4S         24'h00_0008
`define BMS_P_8S         24'h00_0010
`define BMS_P_16S        24'h00_0020
`define BMS_P_32S        24'h00_0040
`define BMS_P_1MIN       24'h00_0078
`define BMS_P_5MIN       24'h00_0258
`define BMS_P_10MIN      24'h00_04B0
`define BMS_P_15MIN      24'h00_0708
`define BMS_P_30MIN      24'h00_0E10
`define BMS_P_45MIN      24'h00_1518
`define BMS_P_60MIN      24'h00_1C20
// Milliseconds in half a second, divided by the tick length for the tick ratio
`define BMS_HALF_SEC_MS  500
`define BMS_FIFO_DEPTH   32
`endif

// ==== design/bms_pkg.sv ====
// Purpose: types for the burst message scheduler
// Assumes: nothing beyond the cfg header
// Notes:   encodings are the device's own
package bms_pkg;
  typedef enum logic [2:0] {
    BMS_CMD_PV     = 3'b000,
    BMS_CMD_PCT    = 3'b001,
    BMS_CMD_DYN    = 3'b010,
    BMS_CMD_MAP8   = 3'b011,
    BMS_CMD_MAP4   = 3'b100,
    BMS_CMD_DIAG   = 3'b101
  } bms_cmd_t;
  typedef enum logic [2:0] {
    BMS_TRG_CONT   = 3'b000,
    BMS_TRG_WINDOW = 3'b001,
    BMS_TRG_RISE   = 3'b010,
    BMS_TRG_FALL   = 3'b011,
    BMS_TRG_CHANGE = 3'b100
  } bms_trig_t;
  typedef enum logic [3:0] {
    BMS_VAR_FLOW   = 4'b0000,
    BMS_VAR_DP     = 4'b0001,
    BMS_VAR_STATIC_PRESSURE_SELECT = 4'b0010,
    BMS_VAR_EXTERNAL_TEMP_SELECT   = 4'b0011,
    BMS_VAR_TOTAL  = 4'b0100,
    BMS_VAR_PV     = 4'b0101,
    BMS_VAR_SV     = 4'b0110,
    BMS_VAR_TV     = 4'b0111,
    BMS_VAR_QV     = 4'b1000,
    BMS_VAR_PCT    = 4'b1001,
    BMS_VAR_LOOP   = 4'b1010,
    BMS_VAR_UNUSED = 4'b1111
  } bms_var_t;
  typedef enum logic [1:0] {
    BMS_ST_IDLE    = 2'b00,
    BMS_ST_EVAL    = 2'b01,
    BMS_ST_PUSH    = 2'b10
  } bms_state_t;
endpackage

// ==== design/bms_fifo.sv ====
// Purpose: holds no logic of its own
// Assumes: nothing
// Notes:   the request FIFO module sits in the scheduler file, so that
//          all design logic lives in one place

// ==== design/bms_sched.sv ====
// Purpose: burst message scheduler for three burst slots
// Assumes: proc_tick_i pulses once per processing cycle, same clock domain
// Notes:   publications queue in a FIFO; a full FIFO holds the slot pending
`timescale 1ns/1ps
`include "bms_cfg.svh"
module bms_sched #(
  parameter int NS    = `BMS_SLOTS,
  parameter int VW    = `BMS_VAL_W,
  parameter int DEPTH = `BMS_FIFO_DEPTH,
  parameter int PROC_MS = 100,
  parameter int TICK_MS = 100
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  input  wire logic                          proc_tick_i,
  input  wire logic [NS-1:0]                 burst_en_i,
  input  wire bms_pkg::bms_cmd_t             cmd_i       [NS],
  input  wire bms_pkg::bms_trig_t            trig_mode_i [NS],
  input  wire logic [3:0]                    upd_code_i  [NS],
  input  wire logic [3:0]                    max_code_i  [NS],
  input  wire logic [VW-1:0]                 trig_lvl_i  [NS],
  input  wire bms_pkg::bms_var_t             src_var_i   [NS],
  input  wire logic [VW-1:0]                 var_val_i   [11],
  output logic                               msg_valid_o,
  input  wire logic                          msg_ready_i,
  output logic [1:0]                         msg_slot_o,
  output bms_pkg::bms_cmd_t                  msg_cmd_o,
  output logic [VW-1:0]                      msg_src_o,
  output logic [NS-1:0]                      slot_active_o
);
  import bms_pkg::*;
  localparam int FW = 2 + 3 + VW;
  // Ticks in half a second, derived from tick length
  localparam int HALF_TICKS = (`BMS_HALF_SEC_MS + TICK_MS - 1) / TICK_MS;
  localparam int PROC_TICKS = (PROC_MS + TICK_MS - 1) / TICK_MS;

  // Period code to tick count; longer codes saturate at 60 min
  function automatic logic [31:0] period_ticks(input logic [3:0] code);
    logic [23:0] half;
    logic [31:0] t;
    half = `BMS_P_60MIN;
    case (code)
      4'h0:    half = `BMS_P_0_5S;
      4'h1:    half = `BMS_P_1S;
      4'h2:    half = `BMS_P_2S;
      4'h3:    half = `BMS_P_4S;
      4'h4:    half = `BMS_P_8S;
      4'h5:    half = `BMS_P_16S;
      4'h6:    half = `BMS_P_32S;
      4'h7:    half = `BMS_P_1MIN;
      4'h8:    half = `BMS_P_5MIN;
      4'h9:    half = `BMS_P_10MIN;
      4'hA:    half = `BMS_P_15MIN;
      4'hB:    half = `BMS_P_30MIN;
      4'hC:    half = `BMS_P_45MIN;
      default: half = `BMS_P_60MIN;
    endcase
    t = 32'(half) * 32'(HALF_TICKS);
    if (t <= 32'(PROC_TICKS)) t = 32'(PROC_TICKS) + 32'h0000_0001;
    return t;
  endfunction

  // Source value selection; unused entries read zero
  function automatic logic [VW-1:0] pick(input bms_var_t v, input logic [VW-1:0] vals [11]);
    if (v == BMS_VAR_UNUSED || 4'(v) > 4'hA) return '0;
    return vals[4'(v)];
  endfunction

  logic [31:0]   upd_cnt_ff  [NS];
  logic [31:0]   max_cnt_ff  [NS];
  logic [VW-1:0] last_ff     [NS];
  logic [NS-1:0] pend_ff;
  logic [1:0]    rr_ff;
  wire           fifo_ready;
  wire  [FW-1:0] fifo_out;
  wire  [NS-1:0] want;
  wire  [NS-1:0] upd_due;
  wire  [NS-1:0] max_due;
  wire  [VW-1:0] src     [NS];
  wire  [1:0]    grant;
  wire           push;

  for (genvar s = 0; s < NS; s++) begin : g_slot
    wire [VW-1:0] lvl = trig_lvl_i[s];
    wire [VW-1:0] cur;
    wire [VW-1:0] lst = last_ff[s];
    wire [VW-1:0] dif = (cur > lst) ? cur - lst : lst - cur;
    wire          hit;
    assign cur        = pick(src_var_i[s], var_val_i);
    assign src[s]     = cur;
    assign upd_due[s] = (upd_cnt_ff[s] + 32'h0000_0001 >= period_ticks(upd_code_i[s]));
    assign max_due[s] = (max_cnt_ff[s] + 32'h0000_0001 >= period_ticks(max_code_i[s]));
    assign hit = (trig_mode_i[s] == BMS_TRG_CONT)   ? 1'b1 :
                 (trig_mode_i[s] == BMS_TRG_WINDOW) ? (dif > lvl) :
                 (trig_mode_i[s] == BMS_TRG_RISE)   ? (cur > lvl) :
                 (trig_mode_i[s] == BMS_TRG_FALL)   ? (cur < lvl) :
                 (trig_mode_i[s] == BMS_TRG_CHANGE) ? (dif >= lvl && dif != '0) : 1'b0;
    assign want[s] = burst_en_i[s] && proc_tick_i && ((upd_due[s] && hit) || max_due[s]);

    // Per-slot timers and last-value store
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        upd_cnt_ff[s] <= '0;
        max_cnt_ff[s] <= '0;
        last_ff[s]    <= '0;
      end else if (ce_i) begin
        if (!burst_en_i[s]) begin
          upd_cnt_ff[s] <= '0;
          max_cnt_ff[s] <= '0;
        end else if (proc_tick_i) begin
          upd_cnt_ff[s] <= upd_due[s] ? '0 : upd_cnt_ff[s] + 32'h0000_0001;
          max_cnt_ff[s] <= want[s] ? '0 : max_cnt_ff[s] + 32'h0000_0001;
        end
        if (want[s]) last_ff[s] <= cur;
      end
    end
  end

  // Round-robin pick among pending slots
  assign grant = pend_ff[rr_ff] ? rr_ff :
                 pend_ff[(rr_ff == 2'd2) ? 2'd0 : rr_ff + 2'd1] ?
                   ((rr_ff == 2'd2) ? 2'd0 : rr_ff + 2'd1) :
                 ((rr_ff == 2'd0) ? 2'd2 : rr_ff - 2'd1);
  assign push  = |pend_ff && fifo_ready;

  // Pending set wins over its own clear; a slot switched off drops its
  // request so nothing is sent for it while the queue is full
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pend_ff <= '0;
      rr_ff   <= 2'd0;
    end else if (ce_i) begin
      pend_ff <= ((pend_ff & ~(push ? (NS'(1) << grant) : '0)) | want) & burst_en_i;
      if (push) rr_ff <= (grant == 2'd2) ? 2'd0 : grant + 2'd1;
    end
  end

  bms_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({grant, 3'(cmd_i[grant]), src[grant]}),
    .out_valid_o (msg_valid_o),
    .out_ready_i (msg_ready_i),
    .out_data_o  (fifo_out)
  );

  assign msg_slot_o    = fifo_out[FW-1 -: 2];
  assign msg_cmd_o     = bms_cmd_t'(fifo_out[VW+2:VW]);
  assign msg_src_o     = fifo_out[VW-1:0];
  assign slot_active_o = burst_en_i;
endmodule

// Request queue between the slots and the host side
// Full and empty are exact; one spare address bit tells the wrap
module bms_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  wire              push;
  wire              pop;
  wire              full;
  wire              empty;

  // Pointer compare, top bit tells wrap
  assign full        = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  assign empty       = (wr_ff == rd_ff);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign push        = ce_i && in_valid_i && !full;
  assign pop         = ce_i && out_ready_i && !empty;
  assign out_data_o  = mem_ff[rd_ff[AW-1:0]];

  // Storage, no reset needed on data
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers; frozen with the clock enable like the rest
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + (AW+1)'(1);
      if (pop)  rd_ff <= rd_ff + (AW+1)'(1);
    end
  end
endmodule

// ==== bench/bms_sched_properties.sv ====
// Purpose: port-level checks of the burst scheduler
// Assumes: one clock; ce_i may drop across ticks, which are then not counted
// Notes:   sees top ports only; bound below
`timescale 1ns/1ps
module bms_sched_properties #(
  parameter int NS = 3,
  parameter int VW = 32
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              proc_tick_i,
  input  wire logic [NS-1:0]     burst_en_i,
  input  wire logic              msg_valid_o,
  input  wire logic              msg_ready_i,
  input  wire logic [1:0]        msg_slot_o,
  input  wire bms_pkg::bms_cmd_t msg_cmd_o,
  input  wire logic [VW-1:0]     msg_src_o,
  input  wire logic [NS-1:0]     slot_active_o
);
  import bms_pkg::*;
  logic [3:0] tck_ff;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Queue empty and every slot off
  sequence s_quiet3;
    (!msg_valid_o && burst_en_i == '0)[*3];
  endsequence
  // Ticks since reset; saturates so it never wraps
  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
      tck_ff <= 4'h0;
    else if (proc_tick_i && ce_i && tck_ff != 4'hF)
      tck_ff <= tck_ff + 4'h1;
  end
  // Enables, queue, payload and timing
  AST_ACT_EN: assert property (slot_active_o == burst_en_i)
    else $error("active flags differ from enables");
  AST_RST_CLR: assert property (disable iff (1'b0) rst_i |=> !msg_valid_o)
    else $error("message pending after reset");
  AST_HOLD: assert property (msg_valid_o && !msg_ready_i |=>
    msg_valid_o && $stable({msg_slot_o, msg_cmd_o, msg_src_o}))
    else $error("message changed before pop");
  AST_SLOT: assert property (msg_valid_o |-> int'(msg_slot_o) < NS)
    else $error("slot number out of range");
  AST_CMD: assert property (msg_valid_o |-> msg_cmd_o <= BMS_CMD_DIAG)
    else $error("illegal command in message");
  AST_EARLY: assert property (msg_valid_o |-> tck_ff >= 4'h5)
    else $error("message before shortest period");
  AST_LAT: assert property ($rose(msg_valid_o) |-> $past(proc_tick_i, 2) ||
    $past(proc_tick_i, 3) || $past(proc_tick_i, 4))
    else $error("message not tied to a tick");
  AST_QUIET: assert property (s_quiet3 |=> !msg_valid_o)
    else $error("message while all slots off");
endmodule
bind bms_sched bms_sched_properties #(.NS(NS), .VW(VW)) u_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .proc_tick_i(proc_tick_i),
  .burst_en_i(burst_en_i), .msg_valid_o(msg_valid_o), .msg_ready_i(msg_ready_i),
  .msg_slot_o(msg_slot_o), .msg_cmd_o(msg_cmd_o), .msg_src_o(msg_src_o),
  .slot_active_o(slot_active_o));

// ==== bench/bms_host_model.sv ====
// Purpose: loop host taking burst messages
// Assumes: bench sets stall off the sampling edge
// Notes:   stalling lets the queue fill
`timescale 1ns/1ps
module bms_host_model #(
  parameter int VW = 32
) (
  input  wire logic              ref_clk_i,
  input  wire logic              stall_i,
  input  wire logic              valid_i,
  output logic                   ready_o,
  input  wire logic [1:0]        slot_i,
  input  wire bms_pkg::bms_cmd_t cmd_i,
  input  wire logic [VW-1:0]     src_i
);
  import bms_pkg::*;
  logic [4:0]    tag_q [$];
  logic [VW-1:0] src_q [$];
  // Ready moves only at the falling edge
  initial ready_o = 1'b0;
  always @(negedge ref_clk_i) ready_o <= !stall_i;
  // Record each word on the edge that pops it
  always @(posedge ref_clk_i) begin
    if (valid_i && ready_o) begin
      tag_q.push_back({slot_i, cmd_i});
      src_q.push_back(src_i);
    end
  end
endmodule

// ==== bench/test_bms_sched.sv ====
// Purpose: self-checking bench of the burst scheduler
// Assumes: default tick of 100 ms, so 0.5 s is 5 ticks
// Notes:   ce_i held low once across ten ticks to show the freeze
`timescale 1ns/1ps
module test_bms_sched;
  import bms_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        tick = 1'b0;
  logic        stall = 1'b0;
  logic        ce = 1'b1;
  logic [2:0]  act;
  logic [2:0]  en = 3'h0;
  bms_cmd_t    cmd [3];
  bms_trig_t   mode [3];
  logic [3:0]  upd [3];
  logic [3:0]  mx [3];
  logic [31:0] lvl [3];
  bms_var_t    sv [3];
  logic [31:0] vals [11];
  logic        valid;
  logic        ready;
  logic [1:0]  slot;
  bms_cmd_t    mcmd;
  logic [31:0] src;
  int          n_mismatch = 0;
  int          compares = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  bms_sched DUT (.ref_clk_i(clk), .rst_i(rst), .ce_i(ce), .proc_tick_i(tick),
    .burst_en_i(en), .cmd_i(cmd), .trig_mode_i(mode), .upd_code_i(upd), .max_code_i(mx),
    .trig_lvl_i(lvl), .src_var_i(sv), .var_val_i(vals), .msg_valid_o(valid),
    .msg_ready_i(ready), .msg_slot_o(slot), .msg_cmd_o(mcmd), .msg_src_o(src),
    .slot_active_o(act));
  bms_host_model host (.ref_clk_i(clk), .stall_i(stall), .valid_i(valid),
    .ready_o(ready), .slot_i(slot), .cmd_i(mcmd), .src_i(src));
  // Compare, count, report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Tick pulses spaced so each push lands first
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge clk);
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
      repeat (5) @(negedge clk);
    end
  endtask
  task automatic drain();
    int k = 0;
    repeat (3) @(negedge clk);
    while (valid === 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k == 200) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic restart();
    rst = 1'b1;
    en = 3'h0;
    repeat (3) @(negedge clk);
    host.src_q.delete();
    host.tag_q.delete();
    rst = 1'b0;
  endtask
  // Two phases of source value per trigger mode, level 100
  task automatic mode_run(input bms_trig_t m, input logic [31:0] v0, input logic [31:0] v1,
                          input int e0, input int e1);
    restart();
    mode[0] = m;
    lvl[0] = 32'h0000_0064;
    sv[0] = BMS_VAR_FLOW;
    en[0] = 1'b1;
    vals[0] = v0;
    ticks(5);
    drain();
    check(host.src_q.size(), e0);
    vals[0] = v1;
    ticks(5);
    drain();
    check(host.src_q.size(), e0 + e1);
    if (e1 > 0)
      check(host.src_q[$], v1);
    $display("mode test %0d done", m);
  endtask
  initial begin
    for (int i = 0; i < 3; i++) begin
      cmd[i] = BMS_CMD_PV;
      mode[i] = BMS_TRG_CONT;
      upd[i] = 4'h0;
      mx[i] = 4'hD;
      lvl[i] = 32'h0000_0000;
      sv[i] = BMS_VAR_FLOW;
    end
    for (int i = 0; i < 11; i++)
      vals[i] = 32'h0000_1000 + 32'(i);
    restart();
    en[0] = 1'b1;
    ticks(4);
    drain();
    check(host.src_q.size(), 0);
    for (int k = 0; k < 12; k++) begin
      cmd[0] = bms_cmd_t'(k % 6);
      sv[0] = bms_var_t'(k < 11 ? k : 15);
      ticks(5);
      drain();
      check(host.src_q[$], k < 11 ? 32'h0000_1000 + 32'(k) : 32'h0000_0000);
      check(32'(host.tag_q[$]), {29'h0, 3'(k % 6)});
    end
    check(host.src_q.size(), 12);
    $display("period and payload test done");
    mode_run(BMS_TRG_CONT, 32'h0000_0007, 32'h0000_0009, 1, 1);
    mode_run(BMS_TRG_WINDOW, 32'h0000_0032, 32'h0000_012C, 0, 1);
    mode_run(BMS_TRG_RISE, 32'h0000_0032, 32'h0000_00C8, 0, 1);
    mode_run(BMS_TRG_FALL, 32'h0000_00C8, 32'h0000_0032, 0, 1);
    mode_run(BMS_TRG_CHANGE, 32'h0000_0064, 32'h0000_0096, 1, 0);
    restart();
    ticks(10);
    drain();
    check(host.src_q.size(), 0);
    check(32'(act), 32'h0000_0000);
    $display("disable test done");
    restart();
    mode[0] = BMS_TRG_RISE;
    vals[0] = 32'h0000_0000;
    mx[0] = 4'h1;
    en[0] = 1'b1;
    ticks(12);
    drain();
    check(host.src_q.size(), 1);
    check(host.src_q[$], 32'h0000_0000);
    $display("max period test done");
    // Frozen timers do not advance; then a 1 s period needs ten ticks
    restart();
    mode[0] = BMS_TRG_CONT;
    upd[0] = 4'h1;
    mx[0] = 4'hD;
    en[0] = 1'b1;
    ce = 1'b0;
    ticks(10);
    drain();
    check(host.src_q.size(), 0);
    ce = 1'b1;
    ticks(9);
    drain();
    check(host.src_q.size(), 0);
    ticks(1);
    drain();
    check(host.src_q.size(), 1);
    upd[0] = 4'h0;
    $display("freeze and period test done");
    restart();
    mode[0] = BMS_TRG_CONT;
    mx[0] = 4'hD;
    en = 3'h7;
    stall = 1'b1;
    ticks(60);
    check(32'(valid), 32'h0000_0001);
    check(host.src_q.size(), 0);
    stall = 1'b0;
    drain();
    check(host.src_q.size(), 35);
    check(32'(act), 32'h0000_0007);
    check(32'(host.tag_q[0]), 32'h0000_0005);
    check(32'(host.tag_q[1]), 32'h0000_0008);
    check(32'(host.tag_q[2]), 32'h0000_0010);
    $display("queue fill test done");
    summarize();
  end
endmodule
